// *** design/fspc_cfg.svh ***
// constants for the flash self-program controller
// assumes one 20 MHz clock shared with the core
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH
// control register bit positions
`define FSPC_BIT_CLR_BUF  4
`define FSPC_BIT_FUSE_RD  3
`define FSPC_BIT_PG_WRITE 2
`define FSPC_BIT_PG_ERASE 1
`define FSPC_BIT_STORE_EN 0
// accepted low five bit patterns
`define FSPC_PAT_LOAD    5'h01
`define FSPC_PAT_ERASE   5'h03
`define FSPC_PAT_WRITE   5'h05
`define FSPC_PAT_FUSE_RD 5'h09
`define FSPC_PAT_CLR_BUF 5'h11
// instruction windows in cycles
`define FSPC_STORE_WIN  3'h4
`define FSPC_LOAD_WIN   3'h3
// pointer values for fuse and lock reads
`define FSPC_Z_FUSE_LOW 2'h0
`define FSPC_Z_LOCK     2'h1
`define FSPC_Z_FUSE_HI  2'h3
`define FSPC_LOCK_PAD   6'h3F
`define FSPC_BYTE_NONE  8'hFF
`define FSPC_ERASED     16'hFFFF
// geometry
`define FSPC_WORD_W     4
// programming time
`define FSPC_CLK_NS     50
`define FSPC_PROG_MIN_NS 3700000
`define FSPC_PROG_MAX_NS 4500000
`define FSPC_PROG_CYC   ((`FSPC_PROG_MIN_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)
`define FSPC_PROG_MAXC  (`FSPC_PROG_MAX_NS / `FSPC_CLK_NS)
`endif

// *** design/fspc_pkg.sv ***
// types for the flash self-program controller
// assumes fspc_cfg.svh supplies the numeric constants
package fspc_pkg;
  typedef enum {FSPC_IDLE, FSPC_ERASE, FSPC_WRITE, FSPC_LOCK} fspc_op_t;

  typedef struct packed {
    logic        erase;
    logic        write;
    logic        lock;
    logic [15:0] page;
  } fspc_flash_cmd_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [1:0] lock;
  } fspc_fuse_t;
endpackage : fspc_pkg

// *** design/fspc_ctrl.sv ***
// flash self-program controller: command arming, page buffer, timing
// assumes core strobes, eeprom busy and fuse bits on ref_clk
`timescale 1ns/1ps
`include "fspc_cfg.svh"

// Summary of operation
// - pattern 03 then store within four cycles erases the indexed page.
// - erase uses only the page index bits; data pair ignored.
// - core stalled for the whole page erase.
// - pattern 01 then store loads data pair at word index, any order.
// - buffer clears after page write, on clear bit, and on reset.
// - eeprom write during loading discards the buffered words.
// - pattern 05 then store writes the buffer into the indexed page.
// - core stalled for the whole page write.
// - ordinary load picks a byte with pointer bit zero.
// - eeprom busy blocks programming and fuse or lock reads.
// - pointer 1 armed read returns lock byte, lock bits in 1:0.
// - armed bits clear on completion or when the window runs out.
// - pointer 0 armed read returns fuse low byte.
// - pointer 3 armed read returns fuse high byte.
// - programmed fuse and lock bits read as zero.
// - unarmed load performs an ordinary flash byte read.
// - erase, write and lock write last between 3.7 and 4.5 ms.
// - reset during a flash operation does not abort it.
// - other low five bit patterns have no effect.
// - store enable stays set until erase or write completes.
module fspc_ctrl #(
  parameter int PROG_CYCLES = `FSPC_PROG_CYC,
  parameter int WORD_W      = `FSPC_WORD_W,
  parameter int CNT_W       = 17
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   ctrl_wr,
  input  wire logic [7:0]             ctrl_wdata,
  output logic      [7:0]             ctrl_rdata,
  input  wire logic                   store_instr,
  input  wire logic                   load_instr,
  input  wire logic [15:0]            z_ptr,
  input  wire logic [15:0]            data_word,
  input  wire logic                   eeprom_busy,
  input  wire logic [15:0]            flash_word,
  output logic      [14:0]            flash_rd_addr,
  input  wire fspc_pkg::fspc_fuse_t   fuses,
  output logic      [7:0]             load_data,
  output logic                        load_valid,
  output logic                        core_stall,
  output fspc_pkg::fspc_flash_cmd_t   flash_cmd,
  output logic                        flash_done,
  output logic      [1:0]             lock_wdata,
  input  wire logic [WORD_W-1:0]      buf_rd_idx,
  output logic      [15:0]            buf_rd_data
);
  localparam int DEPTH = 2 ** WORD_W;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PROG_CYCLES - 1);

  // ==========================================================
  // command arming
  logic [4:0]         cmd_q;
  logic               armed_q;
  logic [2:0]         win_q;
  fspc_pkg::fspc_op_t op_q;
  logic [CNT_W-1:0]   timer_q;
  logic               valid_pat;
  logic               ctrl_take;
  logic               store_ok;
  logic               load_fuse;
  logic               expire;
  logic               op_cmd;
  logic               idle;

  assign idle      = (op_q == fspc_pkg::FSPC_IDLE);
  assign valid_pat = ctrl_wdata[4:0] inside {`FSPC_PAT_LOAD, `FSPC_PAT_ERASE,
                     `FSPC_PAT_WRITE, `FSPC_PAT_FUSE_RD,
                     `FSPC_PAT_CLR_BUF};
  assign ctrl_take = ctrl_wr && valid_pat && !eeprom_busy && idle;
  assign store_ok  = store_instr && armed_q && idle &&
                     (win_q < `FSPC_STORE_WIN);
  assign load_fuse = load_instr && armed_q && (cmd_q == `FSPC_PAT_FUSE_RD) &&
                     (win_q < `FSPC_LOAD_WIN);
  assign expire    = armed_q && (win_q == `FSPC_STORE_WIN - 3'h1) &&
                     !store_ok && !load_fuse;
  assign op_cmd    = cmd_q inside {`FSPC_PAT_ERASE, `FSPC_PAT_WRITE,
                     `FSPC_PAT_FUSE_RD};
  assign ctrl_rdata = {3'h0, cmd_q};
  assign core_stall = !idle;

  always_ff @(posedge ref_clk) begin
    if (!reset_n && idle) begin
      cmd_q   <= 5'h00;
      armed_q <= 1'b0;
      win_q   <= 3'h0;
    end else if (!idle) begin
      armed_q <= 1'b0;
      if (timer_q == '0) begin
        cmd_q <= 5'h00;
      end
    end else if (ctrl_take) begin
      cmd_q   <= ctrl_wdata[4:0];
      armed_q <= 1'b1;
      win_q   <= 3'h0;
    end else if (store_ok || load_fuse || expire) begin
      armed_q <= 1'b0;
      cmd_q   <= (store_ok && op_cmd) ? cmd_q : 5'h00;
    end else if (armed_q) begin
      win_q <= win_q + 3'h1;
    end
  end

  // ==========================================================
  // timed flash operations
  always_ff @(posedge ref_clk) begin
    if (!reset_n && idle) begin
      timer_q    <= '0;
      flash_cmd  <= '0;
      flash_done <= 1'b0;
      lock_wdata <= 2'h0;
    end else if (idle) begin
      flash_done <= 1'b0;
      if (store_ok && op_cmd) begin
        timer_q        <= LAST;
        flash_cmd.page <= z_ptr >> (WORD_W + 1);
        unique case (cmd_q)
          `FSPC_PAT_ERASE: begin
            op_q            <= fspc_pkg::FSPC_ERASE;
            flash_cmd.erase <= 1'b1;
          end
          `FSPC_PAT_WRITE: begin
            op_q            <= fspc_pkg::FSPC_WRITE;
            flash_cmd.write <= 1'b1;
          end
          default: begin
            op_q            <= fspc_pkg::FSPC_LOCK;
            flash_cmd.lock  <= 1'b1;
            lock_wdata      <= data_word[1:0];
          end
        endcase
      end
    end else if (timer_q == '0) begin
      op_q       <= fspc_pkg::FSPC_IDLE;
      flash_cmd  <= '0;
      flash_done <= 1'b1;
    end else begin
      timer_q <= timer_q - CNT_W'(1);
    end
  end

  // ==========================================================
  // temporary page buffer
  logic [DEPTH-1:0] buf_vld_q;
  logic [15:0]      buf_mem_q [DEPTH];
  logic             buf_clr;
  logic             buf_load;

  assign buf_clr  = !reset_n || eeprom_busy ||
                    (ctrl_take && ctrl_wdata[`FSPC_BIT_CLR_BUF]) ||
                    (op_q == fspc_pkg::FSPC_WRITE && timer_q == '0);
  assign buf_load = store_ok && (cmd_q == `FSPC_PAT_LOAD);

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk) begin
      if (buf_load && z_ptr[WORD_W:1] == WORD_W'(i)) begin
        buf_vld_q[i] <= 1'b1;
        buf_mem_q[i] <= data_word;
      end else if (buf_clr) begin
        buf_vld_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      buf_rd_data <= `FSPC_ERASED;
    end else begin
      buf_rd_data <= buf_vld_q[buf_rd_idx] ? buf_mem_q[buf_rd_idx]
                                           : `FSPC_ERASED;
    end
  end

  // ==========================================================
  // load instruction
  assign flash_rd_addr = z_ptr[15:1];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      load_valid <= 1'b0;
      load_data  <= 8'h00;
    end else begin
      load_valid <= load_instr;
      if (load_fuse) begin
        unique case (z_ptr[1:0])
          `FSPC_Z_FUSE_LOW: load_data <= fuses.low;
          `FSPC_Z_LOCK:     load_data <= {`FSPC_LOCK_PAD, fuses.lock};
          `FSPC_Z_FUSE_HI:  load_data <= fuses.high;
          default:      load_data <= `FSPC_BYTE_NONE;
        endcase
      end else if (load_instr) begin
        load_data <= z_ptr[0] ? flash_word[15:8] : flash_word[7:0];
      end
    end
  end

  // ==========================================================
  // checks
  logic [CNT_W-1:0] ela_q;
  always_ff @(posedge ref_clk) begin
    if (idle) begin
      ela_q <= '0;
    end else begin
      ela_q <= ela_q + CNT_W'(1);
    end
  end

  property p_erase_start;
    @(posedge ref_clk) disable iff (!reset_n)
    store_ok && cmd_q == `FSPC_PAT_ERASE |=>
      op_q == fspc_pkg::FSPC_ERASE && flash_cmd.erase &&
      flash_cmd.page == ($past(z_ptr) >> (WORD_W + 1));
  endproperty
  a_erase_start: assert property (p_erase_start)
    else $error("erase did not start");

  property p_stall;
    @(posedge ref_clk) disable iff (!reset_n)
    !idle |-> core_stall && ctrl_rdata[`FSPC_BIT_STORE_EN];
  endproperty
  a_stall: assert property (p_stall)
    else $error("core not stalled or enable dropped");

  property p_page_stable;
    @(posedge ref_clk) disable iff (!reset_n)
    !idle && $past(!idle) |-> $stable(flash_cmd.page);
  endproperty
  a_page_stable: assert property (p_page_stable)
    else $error("page changed during operation");

  property p_load_buf;
    @(posedge ref_clk) disable iff (!reset_n)
    buf_load |=> buf_vld_q[$past(z_ptr[WORD_W:1])] &&
      buf_mem_q[$past(z_ptr[WORD_W:1])] == $past(data_word);
  endproperty
  a_load_buf: assert property (p_load_buf)
    else $error("buffer word not loaded");

  property p_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    buf_clr && !buf_load |=> buf_vld_q == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("buffer not cleared");

  property p_write_start;
    @(posedge ref_clk) disable iff (!reset_n)
    store_ok && cmd_q == `FSPC_PAT_WRITE |=> flash_cmd.write ##1
      core_stall[*3];
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("page write did not start");

  property p_byte;
    @(posedge ref_clk) disable iff (!reset_n)
    load_instr && !load_fuse |=> load_valid && load_data ==
      ($past(z_ptr[0]) ? $past(flash_word[15:8]) : $past(flash_word[7:0]));
  endproperty
  a_byte: assert property (p_byte)
    else $error("wrong flash byte");

  property p_block;
    @(posedge ref_clk) disable iff (!reset_n)
    ctrl_wr && eeprom_busy && !armed_q |=> !armed_q;
  endproperty
  a_block: assert property (p_block)
    else $error("armed during eeprom write");

  property p_lock_read;
    @(posedge ref_clk) disable iff (!reset_n)
    load_fuse && z_ptr[1:0] == `FSPC_Z_LOCK |=>
      load_data == {`FSPC_LOCK_PAD, $past(fuses.lock)} && !armed_q;
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock byte wrong");

  property p_expire;
    @(posedge ref_clk) disable iff (!reset_n)
    ctrl_take ##1 (!store_instr && !load_instr && idle)[*4] |=>
      !armed_q && cmd_q == 5'h00;
  endproperty
  a_expire: assert property (p_expire)
    else $error("window did not expire");

  property p_bad_pattern;
    @(posedge ref_clk) disable iff (!reset_n)
    ctrl_wr && !valid_pat && !armed_q && idle |=> !armed_q;
  endproperty
  a_bad_pattern: assert property (p_bad_pattern)
    else $error("illegal pattern armed");

  property p_duration;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(flash_done) |-> $past(ela_q) == LAST;
  endproperty
  a_duration: assert property (p_duration)
    else $error("operation length wrong");

  property p_fuse_low;
    @(posedge ref_clk) disable iff (!reset_n)
    load_fuse && z_ptr[1:0] == `FSPC_Z_FUSE_LOW |=>
      load_valid && load_data == $past(fuses.low);
  endproperty
  a_fuse_low: assert property (p_fuse_low)
    else $error("fuse low byte wrong");

  property p_fuse_high;
    @(posedge ref_clk) disable iff (!reset_n)
    load_fuse && z_ptr[1:0] == `FSPC_Z_FUSE_HI |=>
      load_valid && load_data == $past(fuses.high);
  endproperty
  a_fuse_high: assert property (p_fuse_high)
    else $error("fuse high byte wrong");

  property p_op_end;
    @(posedge ref_clk) disable iff (!reset_n)
    !idle && timer_q == '0 |=> idle && flash_done && ctrl_rdata == 8'h00;
  endproperty
  a_op_end: assert property (p_op_end)
    else $error("operation did not end cleanly");

  property p_disarm;
    @(posedge ref_clk) disable iff (!reset_n)
    (store_ok || load_fuse) && !ctrl_take |=> !armed_q;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("command still armed after use");

  c_erase: cover property (@(posedge ref_clk) $rose(flash_cmd.erase));
  c_write: cover property (@(posedge ref_clk) $rose(flash_cmd.write));
  c_fuse:  cover property (@(posedge ref_clk) load_fuse);
  c_expire: cover property (@(posedge ref_clk) expire);
endmodule : fspc_ctrl

// *** verification/fspc_core_model.sv ***
// core model: control writes, store and load instructions, flash array
// assumes the controller samples its inputs on rising ref_clk
`timescale 1ns/1ps
module fspc_core_model (
  input  wire logic        ref_clk,
  input  wire logic [14:0] flash_rd_addr,
  output logic             ctrl_wr,
  output logic [7:0]       ctrl_wdata,
  output logic             store_instr,
  output logic             load_instr,
  output logic [15:0]      z_ptr,
  output logic [15:0]      data_word,
  output logic [15:0]      flash_word
);
  // ========
  // flash array: word follows its address
  assign flash_word = {1'h1, flash_rd_addr};
  initial begin
    ctrl_wr     = 1'h0;
    store_instr = 1'h0;
    load_instr  = 1'h0;
    ctrl_wdata  = 8'h00;
    z_ptr       = 16'h0000;
    data_word   = 16'h0000;
  end
  // ========
  // control write, then one instruction gap edges later
  task automatic issue(input logic [7:0] pat, input logic [15:0] z,
                       input logic [15:0] d, input int gap,
                       input logic ld);
    @(negedge ref_clk);
    ctrl_wr    = 1'h1;
    ctrl_wdata = pat;
    z_ptr      = z;
    data_word  = d;
    @(negedge ref_clk);
    ctrl_wr = 1'h0;
    repeat (gap - 1) @(negedge ref_clk);
    if (ld)
      load_instr = 1'h1;
    else
      store_instr = 1'h1;
    @(negedge ref_clk);
    store_instr = 1'h0;
    load_instr  = 1'h0;
    // released operands no longer hold their value
    z_ptr       = ~z;
    data_word   = ~d;
  endtask : issue
endmodule : fspc_core_model

// *** verification/tb_flash_self_program_controller.sv ***
// self-checking bench for the flash self-program controller
// assumes the core model drives every instruction input
`timescale 1ns/1ps
module tb_flash_self_program_controller;
  localparam int PROG = 20;
  logic                      ref_clk, reset_n, eeprom_busy, ctrl_wr;
  logic                      store_instr, load_instr, load_valid;
  logic                      core_stall, flash_done;
  logic [7:0]                ctrl_wdata, ctrl_rdata, load_data;
  logic [15:0]               z_ptr, data_word, flash_word, buf_rd_data;
  logic [14:0]               flash_rd_addr;
  logic [3:0]                buf_rd_idx;
  logic [1:0]                lock_wdata;
  fspc_pkg::fspc_fuse_t      fuses;
  fspc_pkg::fspc_flash_cmd_t flash_cmd;
  int                        n_errors = 0;
  int                        checks_done = 0;
  int                        cycles = 0;

  fspc_ctrl #(.PROG_CYCLES(PROG)) fspc_ctrl_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .store_instr(store_instr), .load_instr(load_instr), .z_ptr(z_ptr),
    .data_word(data_word), .eeprom_busy(eeprom_busy),
    .flash_word(flash_word), .flash_rd_addr(flash_rd_addr),
    .fuses(fuses), .load_data(load_data), .load_valid(load_valid),
    .core_stall(core_stall), .flash_cmd(flash_cmd),
    .flash_done(flash_done), .lock_wdata(lock_wdata),
    .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
  fspc_core_model fspc_core_model_i (
    .ref_clk(ref_clk), .flash_rd_addr(flash_rd_addr), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .store_instr(store_instr),
    .load_instr(load_instr), .z_ptr(z_ptr), .data_word(data_word),
    .flash_word(flash_word));

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  // ========
  // helpers
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [19:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd_buf(input logic [3:0] idx, input logic [15:0] exp);
    @(negedge ref_clk);
    buf_rd_idx = idx;
    repeat (2) @(negedge ref_clk);
    chk("buffer word", {4'h0, exp}, {4'h0, buf_rd_data});
  endtask : rd_buf
  task automatic get_load(input string nm, input logic [7:0] exp);
    int k;
    k = 0;
    while (load_valid !== 1'h1 && k < 3) begin
      @(negedge ref_clk);
      k++;
    end
    chk(nm, {12'h001, exp}, {11'h000, load_valid, load_data});
  endtask : get_load
  task automatic wait_op(input logic [7:0] rd, input logic [18:0] cmd,
                         input int rst_at);
    int n_stall, n_done;
    n_stall = 0;
    n_done = 0;
    for (int i = 0; i < PROG + 8; i++) begin
      if (i == 1) begin
        chk("control readback", {12'h000, rd}, {12'h000, ctrl_rdata});
        chk("flash command", {1'h0, cmd}, {1'h0, flash_cmd});
      end
      if (i == rst_at)
        reset_n = 1'h0;
      if (i == rst_at + 2)
        reset_n = 1'h1;
      n_stall += (core_stall === 1'h1);
      n_done += (flash_done === 1'h1);
      @(negedge ref_clk);
    end
    chk("stall cycles", 20'(PROG), 20'(n_stall));
    chk("done pulses", 20'h1, 20'(n_done));
    chk("control after op", 20'h0, {12'h0, ctrl_rdata});
  endtask : wait_op
  task automatic no_op(input string nm);
    repeat (3) begin
      chk(nm, 20'h0, {19'h0, core_stall});
      @(negedge ref_clk);
    end
    chk(nm, 20'h0, {12'h0, ctrl_rdata});
  endtask : no_op

  // ========
  // scenarios
  task automatic t_program;
    fspc_core_model_i.issue(8'h11, 16'h0000, 16'h0000, 1, 1'h0);
    fspc_core_model_i.issue(8'h01, 16'h0006, 16'h1234, 4, 1'h0);
    fspc_core_model_i.issue(8'h01, 16'h0000, 16'hBEEF, 1, 1'h0);
    rd_buf(4'h3, 16'h1234);
    rd_buf(4'h0, 16'hBEEF);
    rd_buf(4'h5, 16'hFFFF);
    fspc_core_model_i.issue(8'h03, 16'h0A5F, 16'h5555, 4, 1'h0);
    wait_op(8'h03, 19'h40052, -1);
    rd_buf(4'h3, 16'h1234);
    fspc_core_model_i.issue(8'h05, 16'h0A40, 16'hAAAA, 2, 1'h0);
    wait_op(8'h05, 19'h20052, -1);
    rd_buf(4'h3, 16'hFFFF);
  endtask : t_program
  task automatic t_fuse;
    fspc_core_model_i.issue(8'h09, 16'h0000, 16'h0000, 3, 1'h1);
    get_load("fuse low", 8'h5A);
    fspc_core_model_i.issue(8'h09, 16'h0001, 16'h0000, 1, 1'h1);
    get_load("lock byte", 8'hFD);
    fspc_core_model_i.issue(8'h09, 16'h0003, 16'h0000, 2, 1'h1);
    get_load("fuse high", 8'hC3);
    fspc_core_model_i.issue(8'h09, 16'h0001, 16'h0000, 4, 1'h1);
    get_load("late load", 8'h80);
    fspc_core_model_i.issue(8'h00, 16'h0234, 16'h0000, 1, 1'h1);
    get_load("flash low", 8'h1A);
    fspc_core_model_i.issue(8'h00, 16'h0235, 16'h0000, 1, 1'h1);
    get_load("flash high", 8'h81);
    fspc_core_model_i.issue(8'h09, 16'h0000, 16'h0002, 2, 1'h0);
    wait_op(8'h09, 19'h10000, -1);
    chk("lock data", 20'h2, {18'h0, lock_wdata});
  endtask : t_fuse
  task automatic t_refuse;
    logic [7:0] bad [3] = '{8'h07, 8'h0D, 8'h19};
    fspc_core_model_i.issue(8'h03, 16'h0A40, 16'h0000, 5, 1'h0);
    no_op("late store");
    foreach (bad[i]) begin
      fspc_core_model_i.issue(bad[i], 16'h0A40, 16'h0000, 1, 1'h0);
      no_op("bad pattern");
    end
  endtask : t_refuse
  task automatic t_eeprom;
    fspc_core_model_i.issue(8'h01, 16'h0002, 16'h4321, 1, 1'h0);
    rd_buf(4'h1, 16'h4321);
    eeprom_busy = 1'h1;
    fspc_core_model_i.issue(8'h03, 16'h0A40, 16'h0000, 1, 1'h0);
    no_op("busy erase");
    fspc_core_model_i.issue(8'h09, 16'h0001, 16'h0000, 1, 1'h1);
    get_load("busy fuse read", 8'h80);
    eeprom_busy = 1'h0;
    rd_buf(4'h1, 16'hFFFF);
  endtask : t_eeprom
  task automatic t_reset;
    fspc_core_model_i.issue(8'h01, 16'h0004, 16'h7777, 1, 1'h0);
    fspc_core_model_i.issue(8'h03, 16'h0A40, 16'h0000, 1, 1'h0);
    wait_op(8'h03, 19'h40052, 5);
    rd_buf(4'h2, 16'hFFFF);
  endtask : t_reset

  // ========
  // main sequence
  initial begin
    reset_n     = 1'h0;
    eeprom_busy = 1'h0;
    buf_rd_idx  = 4'h0;
    fuses       = '{8'h5A, 8'hC3, 2'h1};
    repeat (8) @(negedge ref_clk);
    reset_n = 1'h1;
    t_program();
    t_fuse();
    t_refuse();
    t_eeprom();
    t_reset();
    summarize();
  end
endmodule : tb_flash_self_program_controller
